/* File: src/fsq_consts.vh */
`ifndef FSQ_CONSTS_VH
`define FSQ_CONSTS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FSQ_ADDR_W          7
`define FSQ_OFF_FLAG        7'h2C
`define FSQ_OFF_DATA        7'h2D
`define FSQ_OFF_SEIZE       7'h2E
`define FSQ_OFF_MARK        7'h2F
`define FSQ_OFF_CTRL        7'h30

// ---------------------------------------------------------------
// control register fields and reset values
// ---------------------------------------------------------------
`define FSQ_CTRL_START      0
`define FSQ_CTRL_TRAIL      1
`define FSQ_CTRL_STD        2
`define FSQ_CTRL_ON         3
`define FSQ_CTRL_CHAN_LO    4
`define FSQ_CTRL_CHAN_HI    5
`define FSQ_RST_BYTE        8'h00
`define FSQ_RST_CHAN        2'h0
`define FSQ_READ_ZERO       8'h00

// ---------------------------------------------------------------
// message buffer and length limits
// ---------------------------------------------------------------
`define FSQ_BUF_AW          6
`define FSQ_BUF_DEPTH       64
`define FSQ_MAX_BYTES       8'h40
`define FSQ_LAST_BIT        3'h7

// ---------------------------------------------------------------
// bit timing
// ---------------------------------------------------------------
`define FSQ_CLK_HZ          125000000
`define FSQ_BAUD_RATE       1200
`define FSQ_BIT_CYCLES      (`FSQ_CLK_HZ / `FSQ_BAUD_RATE)
`define FSQ_TMR_W           17

`endif

/* File: src/fsq_bit_timer.v */
`timescale 1ns/1ps
`include "fsq_consts.vh"

// ---------------------------------------------------------------
// bit period divider: one-cycle tick per bit
// ---------------------------------------------------------------
module fsq_bit_timer #(
    parameter BIT_CYCLES = `FSQ_BIT_CYCLES
) (
    input  wire                    mclk,
    input  wire                    rst,
    input  wire                    restart,
    output reg                     tick
);

    localparam [31:0]           LAST_W = BIT_CYCLES - 1;
    localparam [`FSQ_TMR_W-1:0] LAST   = LAST_W[`FSQ_TMR_W-1:0];
    localparam [`FSQ_TMR_W-1:0] ONE    = {{(`FSQ_TMR_W-1){1'b0}}, 1'b1};

    reg [`FSQ_TMR_W-1:0] cnt_q;

    // restart counts the launch cycle, so the first bit is a full period
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= {`FSQ_TMR_W{1'b0}};
            tick  <= 1'b0;
        end else if (restart) begin
            cnt_q <= ONE;
            tick  <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= {`FSQ_TMR_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + ONE;
            tick  <= 1'b0;
        end
    end

endmodule // fsq_bit_timer

/* File: src/fsq_sequencer.v */
// Functional notes
// - flag_length ones between consecutive message bytes; zero sends none
// - payload_length data bytes sent, flag bits not counted
// - payload_length above 64 acts as 64
// - payload_length zero sends no data bytes
// - seizure sends twice seizure_length zero-one pairs; zero omits it
// - mark phase sends mark_length ones; zero omits it
// - tone_channel_select 00..11 routes to channels 1..4; channel 1 at reset
// - generator works only while generator_on is one; off at reset
// - standard_select zero North American, one United Kingdom; zero at reset
// - trailing_mark_enable zero mutes output after last byte
// - trailing_mark_enable one keeps sending ones after last byte
// - clearing trailing_mark_enable while start is one stops trailing ones
// - software sets transmit_start; device clears it when data all sent, or with trailing_mark_enable one when trailing ones stop
// - all three lengths zero clears start right after it is set
`timescale 1ns/1ps
`include "fsq_consts.vh"

module fsq_sequencer #(
    parameter BIT_CYCLES = `FSQ_BIT_CYCLES
) (
    input  wire                    mclk,
    input  wire                    rst,
    input  wire                    reg_wr_en,
    input  wire                    reg_rd_en,
    input  wire [`FSQ_ADDR_W-1:0]  reg_addr,
    input  wire [7:0]              reg_wdata,
    output reg  [7:0]              reg_rdata,
    input  wire                    buf_wr_en,
    input  wire [`FSQ_BUF_AW-1:0]  buf_addr,
    input  wire [7:0]              buf_wdata,
    output reg                     fsk_bit,
    output reg                     fsk_active,
    output reg  [3:0]              tone_channel_en,
    output reg                     standard_select,
    output reg                     bit_strobe
);

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_SEIZE = 3'h1;
    localparam [2:0] ST_MARK  = 3'h2;
    localparam [2:0] ST_DATA  = 3'h3;
    localparam [2:0] ST_FLAG  = 3'h4;
    localparam [2:0] ST_TRAIL = 3'h5;

    localparam [9:0] CNT_ONE  = 10'h001;
    localparam [6:0] IDX_ONE  = 7'h01;
    localparam [2:0] BIT_ONE  = 3'h1;

    // ---------------------------------------------------------------
    // registers and storage
    // ---------------------------------------------------------------
    reg [7:0]              flag_length_q;
    reg [7:0]              payload_length_q;
    reg [7:0]              seizure_length_q;
    reg [7:0]              mark_length_q;
    reg [1:0]              tone_channel_select_q;
    reg                    generator_on_q;
    reg                    standard_select_q;
    reg                    trailing_mark_enable_q;
    reg                    transmit_start_q;
    reg [7:0]              message_buffer [0:`FSQ_BUF_DEPTH-1];

    reg [2:0]              state_q;
    reg [2:0]              state_d;
    reg [9:0]              cnt_q;
    reg [9:0]              cnt_d;
    reg [6:0]              byte_idx_q;
    reg [6:0]              byte_idx_d;
    reg [2:0]              bit_idx_q;
    reg [2:0]              bit_idx_d;
    reg                    done_d;
    reg                    launch_d;

    wire                   tick;
    wire [6:0]             eff_len;
    wire                   all_zero;
    wire                   start_wr;
    wire                   start_wr_val;
    wire [2:0]             first_ph;
    wire [2:0]             after_seize;
    wire [2:0]             after_mark;
    wire [2:0]             after_data;
    wire [6:0]             next_byte;
    wire [7:0]             len_clamp;

    // ---------------------------------------------------------------
    // bit clock enable
    // ---------------------------------------------------------------
    fsq_bit_timer #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .rst     (rst),
        .restart (launch_d),
        .tick    (tick)
    );

    // ---------------------------------------------------------------
    // phase selection helpers
    // ---------------------------------------------------------------
    // clamp byte count to the buffer size
    assign len_clamp = (payload_length_q > `FSQ_MAX_BYTES) ?
                       `FSQ_MAX_BYTES : payload_length_q;
    assign eff_len   = len_clamp[6:0];
    assign all_zero = (seizure_length_q == `FSQ_RST_BYTE) &&
                      (mark_length_q == `FSQ_RST_BYTE) &&
                      (eff_len == 7'h00);
    assign start_wr     = reg_wr_en && (reg_addr == `FSQ_OFF_CTRL);
    assign start_wr_val = reg_wdata[`FSQ_CTRL_START];

    // next non-empty phase, skipping zero lengths
    assign after_data  = trailing_mark_enable_q ? ST_TRAIL : ST_IDLE;
    assign after_mark  = (eff_len != 7'h00) ? ST_DATA : after_data;
    assign after_seize = (mark_length_q != `FSQ_RST_BYTE) ?
                         ST_MARK : after_mark;
    assign first_ph    = (seizure_length_q != `FSQ_RST_BYTE) ?
                         ST_SEIZE : after_seize;
    assign next_byte   = byte_idx_q + IDX_ONE;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_length_q          <= `FSQ_RST_BYTE;
            payload_length_q       <= `FSQ_RST_BYTE;
            seizure_length_q       <= `FSQ_RST_BYTE;
            mark_length_q          <= `FSQ_RST_BYTE;
            tone_channel_select_q  <= `FSQ_RST_CHAN;
            generator_on_q         <= 1'b0;
            standard_select_q      <= 1'b0;
            trailing_mark_enable_q <= 1'b0;
        end else if (reg_wr_en) begin
            if (reg_addr == `FSQ_OFF_FLAG) begin
                flag_length_q <= reg_wdata;
            end else if (reg_addr == `FSQ_OFF_DATA) begin
                payload_length_q <= reg_wdata;
            end else if (reg_addr == `FSQ_OFF_SEIZE) begin
                seizure_length_q <= reg_wdata;
            end else if (reg_addr == `FSQ_OFF_MARK) begin
                mark_length_q <= reg_wdata;
            end else if (reg_addr == `FSQ_OFF_CTRL) begin
                tone_channel_select_q  <=
                    reg_wdata[`FSQ_CTRL_CHAN_HI:`FSQ_CTRL_CHAN_LO];
                generator_on_q         <= reg_wdata[`FSQ_CTRL_ON];
                standard_select_q      <= reg_wdata[`FSQ_CTRL_STD];
                trailing_mark_enable_q <= reg_wdata[`FSQ_CTRL_TRAIL];
            end
        end
    end

    // message buffer write port
    always @(posedge mclk) begin
        if (buf_wr_en) begin
            message_buffer[buf_addr] <= buf_wdata;
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `FSQ_READ_ZERO;
        end else if (reg_rd_en) begin
            if (reg_addr == `FSQ_OFF_FLAG) begin
                reg_rdata <= flag_length_q;
            end else if (reg_addr == `FSQ_OFF_DATA) begin
                reg_rdata <= payload_length_q;
            end else if (reg_addr == `FSQ_OFF_SEIZE) begin
                reg_rdata <= seizure_length_q;
            end else if (reg_addr == `FSQ_OFF_MARK) begin
                reg_rdata <= mark_length_q;
            end else if (reg_addr == `FSQ_OFF_CTRL) begin
                reg_rdata <= {2'b00, tone_channel_select_q,
                              generator_on_q, standard_select_q,
                              trailing_mark_enable_q, transmit_start_q};
            end else begin
                reg_rdata <= `FSQ_READ_ZERO;
            end
        end
    end

    // ---------------------------------------------------------------
    // phase sequencer, next state
    // ---------------------------------------------------------------
    always @* begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        byte_idx_d = byte_idx_q;
        bit_idx_d  = bit_idx_q;
        done_d     = 1'b0;
        launch_d   = 1'b0;
        if (!generator_on_q) begin
            state_d = ST_IDLE;
        end else if (state_q == ST_IDLE) begin
            if (transmit_start_q && !all_zero) begin
                launch_d   = 1'b1;
                state_d    = first_ph;
                byte_idx_d = 7'h00;
                bit_idx_d  = 3'h0;
                if (first_ph == ST_SEIZE) begin
                    cnt_d = {seizure_length_q, 2'b00};
                end else if (first_ph == ST_MARK) begin
                    cnt_d = {2'b00, mark_length_q};
                end else begin
                    cnt_d = 10'h000;
                end
            end
        end else if (state_q == ST_TRAIL) begin
            if (!trailing_mark_enable_q) begin
                state_d = ST_IDLE;
                done_d  = 1'b1;
            end
        end else if (tick) begin
            case (state_q)
                ST_SEIZE: begin
                    if (cnt_q > CNT_ONE) begin
                        cnt_d = cnt_q - CNT_ONE;
                    end else begin
                        state_d = after_seize;
                        cnt_d   = {2'b00, mark_length_q};
                    end
                end
                ST_MARK: begin
                    if (cnt_q > CNT_ONE) begin
                        cnt_d = cnt_q - CNT_ONE;
                    end else begin
                        state_d = after_mark;
                    end
                end
                ST_DATA: begin
                    if (bit_idx_q != `FSQ_LAST_BIT) begin
                        bit_idx_d = bit_idx_q + BIT_ONE;
                    end else if (next_byte < eff_len) begin
                        bit_idx_d  = 3'h0;
                        byte_idx_d = next_byte;
                        if (flag_length_q != `FSQ_RST_BYTE) begin
                            state_d = ST_FLAG;
                            cnt_d   = {2'b00, flag_length_q};
                        end
                    end else begin
                        state_d = after_data;
                    end
                end
                ST_FLAG: begin
                    if (cnt_q > CNT_ONE) begin
                        cnt_d = cnt_q - CNT_ONE;
                    end else begin
                        state_d = ST_DATA;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
            if (state_d == ST_IDLE) begin
                done_d = 1'b1;
            end
        end
        // a write of zero to the start bit aborts the run
        if (start_wr && !start_wr_val) begin
            state_d = ST_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // sequencer state registers
    // ---------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 10'h000;
            byte_idx_q <= 7'h00;
            bit_idx_q  <= 3'h0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            byte_idx_q <= byte_idx_d;
            bit_idx_q  <= bit_idx_d;
        end
    end

    // ---------------------------------------------------------------
    // start bit: software set wins over hardware clear
    // ---------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            transmit_start_q <= 1'b0;
        end else if (start_wr) begin
            transmit_start_q <= start_wr_val;
        end else if (transmit_start_q && all_zero &&
                     state_q == ST_IDLE) begin
            transmit_start_q <= 1'b0;
        end else if (done_d) begin
            transmit_start_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // output stage
    // ---------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            fsk_bit         <= 1'b1;
            fsk_active      <= 1'b0;
            tone_channel_en <= 4'h0;
            standard_select <= 1'b0;
            bit_strobe      <= 1'b0;
        end else begin
            standard_select <= standard_select_q;
            bit_strobe      <= (tick || launch_d) &&
                               (state_d != ST_IDLE);
            fsk_active      <= (state_d != ST_IDLE);
            if (state_d != ST_IDLE) begin
                tone_channel_en <= 4'h1 << tone_channel_select_q;
            end else begin
                tone_channel_en <= 4'h0;
            end
            case (state_d)
                ST_SEIZE: fsk_bit <= cnt_d[0];
                ST_DATA:  fsk_bit <= cur_byte_d(bit_idx_d);
                default:  fsk_bit <= 1'b1;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // data bit pick, lsb first, from the byte about to be sent
    // ---------------------------------------------------------------
    function cur_byte_d;
        input [2:0] idx;
        reg   [7:0] b;
        begin
            b          = message_buffer[byte_idx_d[`FSQ_BUF_AW-1:0]];
            cur_byte_d = b[idx];
        end
    endfunction

endmodule // fsq_sequencer

/* File: tb/fsq_seq_properties.sv */
`timescale 1ns/1ps
`include "fsq_consts.vh"

// ----------------------------------------------------------
// port checker of the caller id sequencer
// ----------------------------------------------------------
module fsq_seq_properties #(
    parameter BIT_CYCLES = 4
) (
    input wire                   mclk,
    input wire                   rst,
    input wire                   reg_wr_en,
    input wire                   reg_rd_en,
    input wire [`FSQ_ADDR_W-1:0] reg_addr,
    input wire [7:0]             reg_wdata,
    input wire [7:0]             reg_rdata,
    input wire                   fsk_active,
    input wire [3:0]             tone_channel_en,
    input wire                   standard_select,
    input wire                   bit_strobe
);
    reg  [31:0] len_q;
    reg  [5:0]  ctl_q;
    reg  [1:0]  age_q;
    reg  [16:0] gap_q;
    reg         run_q;
    wire        is_len = reg_addr >= `FSQ_OFF_FLAG &&
                         reg_addr <= `FSQ_OFF_MARK;
    wire        ctl_wr = reg_wr_en && reg_addr == `FSQ_OFF_CTRL;
    wire        unm_rd = reg_rd_en && !is_len &&
                         reg_addr != `FSQ_OFF_CTRL;
    wire [7:0]  len_sel = len_q[reg_addr[1:0]*8 +: 8];

    // shadow of host writes, age of control write, bit spacing
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            len_q <= 32'h0;
            ctl_q <= 6'h00;
            age_q <= 2'h3;
            gap_q <= 17'h0;
            run_q <= 1'b0;
        end else begin
            if (reg_wr_en && is_len)
                len_q[reg_addr[1:0]*8 +: 8] <= reg_wdata;
            if (ctl_wr)
                ctl_q <= reg_wdata[5:0];
            age_q <= ctl_wr ? 2'h0 : (age_q == 2'h3 ? 2'h3 : age_q + 2'h1);
            gap_q <= bit_strobe ? 17'h1 : gap_q + 17'h1;
            run_q <= fsk_active && (run_q || bit_strobe);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chan_route_a: assert property (fsk_active && age_q == 2'h3 |->
        tone_channel_en == (4'h1 << ctl_q[5:4])) else $error("bad channel");
    mute_idle_a: assert property (!fsk_active |->
        tone_channel_en == 4'h0) else $error("channel on while muted");
    std_copy_a: assert property (age_q == 2'h3 |->
        standard_select == ctl_q[2]) else $error("standard copy wrong");
    gen_off_a: assert property (age_q == 2'h3 && !ctl_q[3] |->
        !fsk_active) else $error("active with generator off");
    strobe_live_a: assert property (bit_strobe |-> fsk_active)
        else $error("bit strobe while muted");
    bit_space_a: assert property (bit_strobe && run_q |->
        gap_q == BIT_CYCLES) else $error("bit period wrong");
    first_bit_a: assert property ($rose(fsk_active) |-> bit_strobe)
        else $error("tone on without first bit");
    zero_start_a: assert property (ctl_wr && reg_wdata[0] &&
        len_q[31:8] == 24'h0 |=> !fsk_active [*3])
        else $error("started with all lengths zero");
    unmapped_rd_a: assert property (unm_rd |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    len_back_a: assert property (reg_rd_en && !reg_wr_en && is_len |=>
        reg_rdata == $past(len_sel)) else $error("length readback wrong");

    start_seen_c: cover property (ctl_wr && reg_wdata[0]);
    trail_on_c: cover property (fsk_active && ctl_q[1] && age_q == 2'h3);
    tone_end_c: cover property ($fell(fsk_active));
endmodule // fsq_seq_properties

/* File: tb/fsq_line_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------
// line side receiver: collects each bit put on the line
// ----------------------------------------------------------
module fsq_line_model (
    input wire mclk,
    input wire rst,
    input wire fsk_bit,
    input wire fsk_active,
    input wire bit_strobe
);
    logic got [$];

    // a bit counts only while the tone is on
    always @(posedge mclk) begin
        if (!rst && bit_strobe && fsk_active)
            got.push_back(fsk_bit);
    end
endmodule // fsq_line_model

/* File: tb/fsk_caller_id_sequencer_tb_top.sv */
`timescale 1ns/1ps
`include "fsq_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end

// ----------------------------------------------------------
// top bench of the caller id sequencer
// ----------------------------------------------------------
module fsk_caller_id_sequencer_tb_top;
    localparam int BITC = 4;
    logic        mclk;
    logic        rst = 1'b1;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        buf_wr_en = 1'b0;
    logic [5:0]  buf_addr = 6'h00;
    logic [7:0]  buf_wdata = 8'h00;
    logic        fsk_bit;
    logic        fsk_active;
    logic [3:0]  tone_channel_en;
    logic        standard_select;
    logic        bit_strobe;
    logic [31:0] lf = 32'he376;
    logic [7:0]  msg [0:63];
    logic        exp_q [$];
    logic [7:0]  d;
    logic [7:0]  w;
    int          failures = 0;
    int          checks = 0;
    int          i;
    int          k;

    fsq_sequencer #(.BIT_CYCLES(BITC)) u_dut (
        .mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .buf_wr_en(buf_wr_en), .buf_addr(buf_addr),
        .buf_wdata(buf_wdata), .fsk_bit(fsk_bit), .fsk_active(fsk_active),
        .tone_channel_en(tone_channel_en),
        .standard_select(standard_select), .bit_strobe(bit_strobe));
    fsq_line_model u_line (
        .mclk(mclk), .rst(rst), .fsk_bit(fsk_bit),
        .fsk_active(fsk_active), .bit_strobe(bit_strobe));

    // free running clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // random byte source
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction

    // host register and buffer cycles, one strobe cycle each
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(negedge mclk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(negedge mclk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        v = reg_rdata;
    endtask
    task automatic bw(input logic [5:0] a, input logic [7:0] v);
        @(negedge mclk);
        buf_wr_en = 1'b1;
        buf_addr = a;
        buf_wdata = v;
        @(negedge mclk);
        buf_wr_en = 1'b0;
    endtask

    // expected line bits of one message
    task automatic build(input logic [7:0] sl, ml, dl, fl);
        int n;
        int b;
        int j;
        n = (dl > 64) ? 64 : dl;
        exp_q.delete();
        for (j = 0; j < 4 * sl; j++)
            exp_q.push_back(j[0]);
        repeat (ml) exp_q.push_back(1'b1);
        for (b = 0; b < n; b++) begin
            if (b > 0)
                repeat (fl) exp_q.push_back(1'b1);
            for (j = 0; j < 8; j++)
                exp_q.push_back(msg[b][j]);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one message: load, start, watch the line, judge the end
    task automatic run_case(input logic [7:0] sl, ml, dl, fl, ch, st, tr);
        logic [7:0] c;
        logic [7:0] v;
        int j;
        for (j = 0; j < 64; j++) begin
            msg[j] = rnd();
            bw(6'(j), msg[j]);
        end
        wr(`FSQ_OFF_FLAG, fl);
        wr(`FSQ_OFF_DATA, dl);
        wr(`FSQ_OFF_SEIZE, sl);
        wr(`FSQ_OFF_MARK, ml);
        build(sl, ml, dl, fl);
        u_line.got.delete();
        c = {2'b00, ch[1:0], 1'b1, st[0], tr[0], 1'b1};
        wr(`FSQ_OFF_CTRL, c);
        for (j = 0; j < exp_q.size() * BITC + 40; j++) begin
            @(negedge mclk);
            if (u_line.got.size() >= exp_q.size())
                break;
            if (fsk_active)
                `CHK(tone_channel_en, 4'h1 << ch[1:0])
        end
        if (u_line.got.size() < exp_q.size()) begin
            failures++;
            complete_run();
        end
        repeat (BITC + 3) @(negedge mclk);
        `CHK(fsk_active, tr[0])
        `CHK(standard_select, st[0])
        rd(`FSQ_OFF_CTRL, v);
        `CHK(v, {c[7:1], tr[0]})
        if (tr[0]) begin
            wr(`FSQ_OFF_CTRL, c & 8'hFD);
            repeat (2) @(negedge mclk);
            `CHK(fsk_active, 1'b0)
            rd(`FSQ_OFF_CTRL, v);
            `CHK(v, c & 8'hFC)
        end
        for (j = 0; j < u_line.got.size(); j++)
            `CHK(u_line.got[j], j < exp_q.size() ? exp_q[j] : 1'b1)
        if (!tr[0])
            `CHK(u_line.got.size(), exp_q.size())
        $display("case sl %0d ml %0d dl %0d fl %0d done", sl, ml, dl, fl);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 5; i++) begin
            rd(7'(`FSQ_OFF_FLAG + i), d);
            `CHK(d, 8'h00)
        end
        wr(7'h31, rnd());
        rd(7'h31, d);
        `CHK(d, 8'h00)
        for (i = 0; i < 4; i++) begin
            w = rnd();
            wr(7'(`FSQ_OFF_FLAG + i), w);
            rd(7'(`FSQ_OFF_FLAG + i), d);
            `CHK(d, w)
        end
        wr(`FSQ_OFF_CTRL, 8'hF4);
        rd(`FSQ_OFF_CTRL, d);
        `CHK(d, 8'h34)
        `CHK(standard_select, 1'b1)
        for (i = 0; i < 4; i++)
            wr(7'(`FSQ_OFF_FLAG + i), 8'h00);
        wr(`FSQ_OFF_CTRL, 8'h09);
        repeat (2) @(negedge mclk);
        rd(`FSQ_OFF_CTRL, d);
        `CHK(d, 8'h08)
        `CHK(fsk_active, 1'b0)
        wr(`FSQ_OFF_MARK, 8'h03);
        wr(`FSQ_OFF_CTRL, 8'h01);
        repeat (20) @(negedge mclk);
        `CHK(fsk_active, 1'b0)
        rd(`FSQ_OFF_CTRL, d);
        `CHK(d, 8'h01)
        wr(`FSQ_OFF_CTRL, 8'h00);
        $display("register tests done");
        run_case(0, 1, 1, 0, 0, 0, 0);
        run_case(2, 3, 3, 2, 1, 1, 0);
        run_case(1, 0, 0, 0, 2, 0, 0);
        run_case(0, 0, 70, 1, 3, 1, 0);
        run_case(1, 2, 2, 255, 0, 1, 1);
        for (k = 0; k < 3; k++)
            run_case(rnd() % 3, rnd() % 5, rnd() % 5 + 1, rnd() % 4,
                     rnd() % 4, rnd() % 2, 0);
        complete_run();
    end
endmodule // fsk_caller_id_sequencer_tb_top

bind fsq_sequencer fsq_seq_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
    .mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fsk_active(fsk_active), .tone_channel_en(tone_channel_en),
    .standard_select(standard_select), .bit_strobe(bit_strobe));
